// ### design/lww_ctrl.sv
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/10ps
module lww_ctrl
    import lww_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Engine sequencing
    input wire logic acq_start,
    input wire logic vol_win_start,
    input wire logic frame_win_start,
    input wire logic vol_done,
    output logic line_win_open,
    output logic frame_done,
    // Trigger sources
    input wire lww_trig_t trig_in,
    // Incoming stream
    input wire logic in_valid,
    input wire lww_pkt_t in_pkt,
    // Windowed stream
    output logic out_valid,
    output lww_pkt_t out_pkt
);

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------

    // Conditioning of a trigger level against its previous sample
    function automatic logic cond_met(input logic [3:0] code,
                                      input logic cur, input logic prev);
        logic r;
        r = 1'b0;
        case (code)
            LWW_COND_RISE: r = cur & ~prev;
            LWW_COND_FALL: r = ~cur & prev;
            LWW_COND_HIGH: r = cur;
            LWW_COND_LOW: r = ~cur;
            LWW_COND_EITHER: r = cur ^ prev;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // Pick a trigger source; undefined codes select nothing
    function automatic logic src_pick(input logic [3:0] code,
                                      input lww_trig_t t);
        logic [4:0] v;
        logic r;
        v = t;
        r = 1'b0;
        if (code <= LWW_MAX_SRC) begin
            r = v[code[2:0]];
        end
        return r;
    endfunction

    // Keep a 4-bit code only if legal, else store zero
    function automatic logic [3:0] legal(input logic [3:0] code,
                                         input logic [3:0] max);
        return (code <= max) ? code : 4'h0;
    endfunction

    // Match of the register address against a counter slot
    function automatic logic cnt_hit(input logic [7:0] a, input int i);
        logic [7:0] off;
        off = LWW_ADDR_CNT_BASE + 8'(i) * LWW_ADDR_CNT_STEP;
        return a == off;
    endfunction

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    logic [3:0] close_cond_r, close_src_r, close_mode_r;
    logic [3:0] open_cond_r, open_src_r, open_mode_r, sync_r;
    logic [15:0] lines_size_r, lines_to_skip_r;
    logic [15:0] words_size_r, words_to_skip_r;
    logic wr_ctrl, wr_ldim, wr_wdim;

    assign wr_ctrl = reg_wr && (reg_addr == LWW_ADDR_LINE_CTRL);
    assign wr_ldim = reg_wr && (reg_addr == LWW_ADDR_LINE_DIM);
    assign wr_wdim = reg_wr && (reg_addr == LWW_ADDR_WORD_DIM);

    // Line window control, undefined codes stored as zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            close_cond_r <= 4'h0;
            close_src_r <= 4'h0;
            close_mode_r <= 4'h0;
            open_cond_r <= 4'h0;
            open_src_r <= 4'h0;
            open_mode_r <= 4'h0;
            sync_r <= 4'h0;
        end else if (wr_ctrl) begin
            close_cond_r <= legal(reg_wdata[LWW_CLOSE_COND_LSB+:4],
                                  LWW_COND_EITHER);
            close_src_r <= legal(reg_wdata[LWW_CLOSE_SRC_LSB+:4],
                                 LWW_MAX_SRC);
            close_mode_r <= legal(reg_wdata[LWW_CLOSE_MODE_LSB+:4],
                                  LWW_MODE_TRIG);
            open_cond_r <= legal(reg_wdata[LWW_OPEN_COND_LSB+:4],
                                 LWW_COND_EITHER);
            open_src_r <= legal(reg_wdata[LWW_OPEN_SRC_LSB+:4],
                                LWW_MAX_SRC);
            open_mode_r <= legal(reg_wdata[LWW_OPEN_MODE_LSB+:4],
                                 LWW_MODE_TRIG);
            sync_r <= legal(reg_wdata[LWW_SYNC_LSB+:4],
                            LWW_SYNC_SOL);
        end
    end

    // Line and word window dimensions
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lines_size_r <= 16'h0000;
            lines_to_skip_r <= 16'h0000;
            words_size_r <= 16'h0000;
            words_to_skip_r <= 16'h0000;
        end else begin
            if (wr_ldim) begin
                lines_size_r <= reg_wdata[LWW_SIZE_LSB+:16];
                lines_to_skip_r <= reg_wdata[LWW_SKIP_LSB+:16];
            end
            if (wr_wdim) begin
                words_size_r <= reg_wdata[LWW_SIZE_LSB+:16];
                words_to_skip_r <= reg_wdata[LWW_SKIP_LSB+:16];
            end
        end
    end

    // ----------------------------------------------------------------
    // Trigger conditioning
    // ----------------------------------------------------------------
    lww_trig_t trig_prev_r;
    logic open_hit, close_hit;

    // Previous trigger sample for edge functions
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_prev_r <= '0;
        end else begin
            trig_prev_r <= trig_in;
        end
    end

    assign open_hit = cond_met(open_cond_r, src_pick(open_src_r, trig_in),
        src_pick(open_src_r, trig_prev_r));
    assign close_hit = cond_met(close_cond_r,
        src_pick(close_src_r, trig_in),
        src_pick(close_src_r, trig_prev_r));

    // ----------------------------------------------------------------
    // Line window state machine
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT_OPEN, ST_OPEN} lww_state_t;
    lww_state_t state_r;
    logic [15:0] line_idx_r, lines_done_r, word_idx_r;
    logic synced_r, close_pend_r;
    logic accept, line_end, acq_line, word_take, size_done;
    logic open_now, close_now;

    assign acq_line = line_idx_r >= lines_to_skip_r;
    assign size_done = (close_mode_r == LWW_MODE_SIZE)
        && (lines_done_r >= lines_size_r);
    // Packets before the marker are dropped when syncing per line
    assign accept = (state_r == ST_OPEN) && in_valid && !size_done
        && ((sync_r == LWW_SYNC_NONE) || synced_r
            || in_pkt.start_of_line_marker);
    assign line_end = accept && in_pkt.eol;
    assign word_take = accept && acq_line
        && (word_idx_r >= words_to_skip_r)
        && (word_idx_r - words_to_skip_r < words_size_r);
    assign open_now = (state_r == ST_WAIT_OPEN)
        && ((open_mode_r == LWW_MODE_SIZE) || open_hit);
    assign close_now = (state_r == ST_OPEN)
        && (size_done
            || ((close_mode_r == LWW_MODE_TRIG) && line_end
                && (close_pend_r || close_hit)));

    // Window sequencing
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (frame_win_start) begin
                        state_r <= ST_WAIT_OPEN;
                    end
                end
                ST_WAIT_OPEN: begin
                    if (open_now) begin
                        state_r <= ST_OPEN;
                    end
                end
                ST_OPEN: begin
                    if (close_now) begin
                        state_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Pending close trigger, held until the next line boundary
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            close_pend_r <= 1'b0;
        end else if (state_r != ST_OPEN || close_now) begin
            close_pend_r <= 1'b0;
        end else if (close_mode_r == LWW_MODE_TRIG && close_hit) begin
            close_pend_r <= 1'b1;
        end
    end

    // Line position and per-line sync state
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            line_idx_r <= 16'h0000;
            lines_done_r <= 16'h0000;
            synced_r <= 1'b0;
        end else if (open_now) begin
            line_idx_r <= 16'h0000;
            lines_done_r <= 16'h0000;
            synced_r <= 1'b0;
        end else if (line_end) begin
            if (line_idx_r != 16'hffff) begin
                line_idx_r <= line_idx_r + 16'h0001;
            end
            if (acq_line) begin
                lines_done_r <= lines_done_r + 16'h0001;
            end
            synced_r <= 1'b0;
        end else if (accept) begin
            synced_r <= 1'b1;
        end
    end

    // Word position within the current line
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            word_idx_r <= 16'h0000;
        end else if (open_now || line_end) begin
            word_idx_r <= 16'h0000;
        end else if (accept && word_idx_r != 16'hffff) begin
            word_idx_r <= word_idx_r + 16'h0001;
        end
    end

    // Registered outputs
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_pkt <= '0;
            frame_done <= 1'b0;
        end else begin
            out_valid <= word_take;
            if (word_take) begin
                out_pkt <= in_pkt;
            end
            frame_done <= close_now;
        end
    end

    assign line_win_open = (state_r == ST_OPEN);

    // ----------------------------------------------------------------
    // Acquisition counters
    // ----------------------------------------------------------------
    logic [15:0] cnt_r [LWW_NUM_CNT];
    logic [1:0] clr_pt_r [LWW_NUM_CNT];
    logic [LWW_NUM_CNT-1:0] cnt_inc;
    logic [3:0] clr_evt;

    // Increment sources: volume, frame, line, word
    assign cnt_inc = {word_take, line_end && acq_line, close_now,
                      vol_done};
    assign clr_evt = {open_now, frame_win_start, vol_win_start, acq_start};

    genvar gi;
    generate
        for (gi = 0; gi < LWW_NUM_CNT; gi++) begin : g_cnt
            logic wr_hit, clr;
            assign wr_hit = reg_wr && cnt_hit(reg_addr, gi);
            // Clear point or software zero, increment still counted
            assign clr = clr_evt[clr_pt_r[gi]]
                || (wr_hit && reg_wdata[LWW_CNT_LSB+:16] == 16'h0000);

            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    cnt_r[gi] <= LWW_RST_CNT;
                end else if (clr) begin
                    cnt_r[gi] <= {15'h0000, cnt_inc[gi]};
                end else if (cnt_inc[gi]) begin
                    cnt_r[gi] <= cnt_r[gi] + 16'h0001;
                end
            end

            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    clr_pt_r[gi] <= LWW_CLR_ACQ;
                end else if (wr_hit) begin
                    clr_pt_r[gi] <= reg_wdata[LWW_CLR_PT_LSB+:2];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    logic [31:0] rd_mux;

    // Read selection, unmapped and reserved bits read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (reg_addr == LWW_ADDR_LINE_CTRL) begin
            rd_mux = {4'h0, sync_r, open_mode_r, open_src_r, open_cond_r,
                      close_mode_r, close_src_r, close_cond_r};
        end else if (reg_addr == LWW_ADDR_LINE_DIM) begin
            rd_mux = {lines_to_skip_r, lines_size_r};
        end else if (reg_addr == LWW_ADDR_WORD_DIM) begin
            rd_mux = {words_to_skip_r, words_size_r};
        end else begin
            for (int i = 0; i < LWW_NUM_CNT; i++) begin
                if (cnt_hit(reg_addr, i)) begin
                    rd_mux = {2'h0, clr_pt_r[i], 12'h000, cnt_r[i]};
                end
            end
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= LWW_RST_REG;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

endmodule

// ### inc/lww_pkg.sv
package lww_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] LWW_ADDR_LINE_CTRL = 8'h00;
    localparam logic [7:0] LWW_ADDR_LINE_DIM = 8'h04;
    localparam logic [7:0] LWW_ADDR_WORD_DIM = 8'h08;
    localparam logic [7:0] LWW_ADDR_CNT_BASE = 8'h0c;
    localparam logic [7:0] LWW_ADDR_CNT_STEP = 8'h04;
    localparam int LWW_NUM_CNT = 4;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int LWW_CLOSE_COND_LSB = 0;
    localparam int LWW_CLOSE_SRC_LSB = 4;
    localparam int LWW_CLOSE_MODE_LSB = 8;
    localparam int LWW_OPEN_COND_LSB = 12;
    localparam int LWW_OPEN_SRC_LSB = 16;
    localparam int LWW_OPEN_MODE_LSB = 20;
    localparam int LWW_SYNC_LSB = 24;
    localparam int LWW_SIZE_LSB = 0;
    localparam int LWW_SKIP_LSB = 16;
    localparam int LWW_CNT_LSB = 0;
    localparam int LWW_CLR_PT_LSB = 28;

    // ----------------------------------------------------------------
    // Codes and reset values
    // ----------------------------------------------------------------
    localparam logic [3:0] LWW_COND_RISE = 4'h0;
    localparam logic [3:0] LWW_COND_FALL = 4'h1;
    localparam logic [3:0] LWW_COND_HIGH = 4'h2;
    localparam logic [3:0] LWW_COND_LOW = 4'h3;
    localparam logic [3:0] LWW_COND_EITHER = 4'h4;
    localparam logic [3:0] LWW_MAX_SRC = 4'h4;
    localparam logic [3:0] LWW_MODE_SIZE = 4'h0;
    localparam logic [3:0] LWW_MODE_TRIG = 4'h1;
    localparam logic [3:0] LWW_SYNC_NONE = 4'h0;
    localparam logic [3:0] LWW_SYNC_SOL = 4'h1;
    localparam logic [1:0] LWW_CLR_ACQ = 2'h0;
    localparam logic [1:0] LWW_CLR_VOL = 2'h1;
    localparam logic [1:0] LWW_CLR_FRAME = 2'h2;
    localparam logic [1:0] LWW_CLR_LINE = 2'h3;
    localparam logic [31:0] LWW_RST_REG = 32'h0000_0000;
    localparam logic [15:0] LWW_RST_CNT = 16'h0000;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic start_of_line_marker;
        logic eol;
        logic [127:0] data;
    } lww_pkt_t;

    typedef struct packed {
        logic quad;
        logic div;
        logic enc_b;
        logic enc_a;
        logic trig;
    } lww_trig_t;

endpackage

// ### sim/lww_src.sv
`timescale 1ns/10ps
module lww_src
    import lww_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Stream towards the block
    output logic in_valid,
    output lww_pkt_t in_pkt
);

    // Idle stream at time zero
    initial begin
        in_valid = 1'b0;
        in_pkt = '0;
    end

    // One packet per clock, launched just after the edge
    task automatic put(input logic start_of_line_marker, input logic eol,
                       input logic [31:0] tag);
        in_valid <= 1'b1;
        in_pkt <= '{start_of_line_marker: start_of_line_marker, eol: eol, data: {96'h0, tag}};
        @(posedge ref_clk);
    endtask

    // Lines of words, each preceded by junk without a start marker
    task automatic send(input int junk, input int lines, input int words);
        for (int l = 0; l < lines; l++) begin
            for (int j = 0; j < junk; j++) begin
                put(1'b0, 1'b0, {16'(l), 16'h8000 | 16'(j)});
            end
            for (int w = 0; w < words; w++) begin
                put(w == 0, w == words - 1, {16'(l), 16'(w)});
            end
            // Released: show the inverse, never the last word
            in_valid <= 1'b0;
            in_pkt <= ~in_pkt;
            @(posedge ref_clk);
        end
    endtask

endmodule

// ### sim/lww_chk.sv
`timescale 1ns/10ps
module lww_chk
    import lww_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Windowing and stream
    input wire logic frame_win_start,
    input wire logic line_win_open,
    input wire logic frame_done,
    input wire lww_trig_t trig_in,
    input wire logic in_valid,
    input wire lww_pkt_t in_pkt,
    input wire logic out_valid,
    input wire lww_pkt_t out_pkt
);
    logic [31:0] ctl_r;
    logic [4:0] trig_v;
    logic sel_d1_r;
    logic sel_d2_r;
    logic trig_ok;

    // Shadow of the control register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_r <= 32'h0;
        end else if (reg_wr && reg_addr == 8'h00) begin
            ctl_r <= reg_wdata;
        end
    end

    // Two samples of the selected open trigger
    assign trig_v = trig_in;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_d1_r <= 1'b0;
            sel_d2_r <= 1'b0;
        end else begin
            sel_d1_r <= trig_v[ctl_r[18:16]];
            sel_d2_r <= sel_d1_r;
        end
    end

    // Open condition as it stood when the window opened
    always_comb begin
        case (ctl_r[15:12])
            LWW_COND_RISE: trig_ok = sel_d1_r && !sel_d2_r;
            LWW_COND_FALL: trig_ok = !sel_d1_r && sel_d2_r;
            LWW_COND_HIGH: trig_ok = sel_d1_r;
            LWW_COND_LOW: trig_ok = !sel_d1_r;
            LWW_COND_EITHER: trig_ok = sel_d1_r != sel_d2_r;
            default: trig_ok = 1'b0;
        endcase
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence wr_dim_s;
        reg_wr && (reg_addr == 8'h04 || reg_addr == 8'h08);
    endsequence
    sequence rd_same_s;
        reg_rd && reg_addr == $past(reg_addr);
    endsequence
    sequence open_req_s;
        frame_win_start && !line_win_open && ctl_r[27:20] == 8'h00;
    endsequence

    rdata_idle_a: assert property (
        !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("rdata not idle");
    unmapped_rd_a: assert property (
        reg_rd && reg_addr > 8'h18 |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    ctrl_resv_a: assert property (
        reg_rd && reg_addr == 8'h00 |=> reg_rdata[31:28] == 4'h0)
        else $error("control reserved bits set");
    cnt_resv_a: assert property (
        reg_rd && reg_addr >= 8'h0c && reg_addr <= 8'h18 |=>
        reg_rdata[31:30] == 2'h0 && reg_rdata[27:16] == 12'h0)
        else $error("counter reserved bits set");
    dim_back_a: assert property (
        wr_dim_s ##1 rd_same_s |=> reg_rdata == $past(reg_wdata, 2))
        else $error("dimension readback wrong");
    out_cause_a: assert property (
        out_valid |-> $past(in_valid) && $past(line_win_open) &&
        out_pkt == $past(in_pkt)) else $error("word out without cause");
    done_pulse_a: assert property (
        frame_done |=> !frame_done) else $error("frame done too long");
    close_done_a: assert property (
        $fell(line_win_open) |-> ##[0:1] frame_done)
        else $error("no frame done after close");
    imm_open_a: assert property (
        open_req_s |-> ##2 line_win_open) else $error("immediate open late");
    trig_ok_a: assert property (
        $rose(line_win_open) && ctl_r[23:20] == 4'h1 |-> trig_ok)
        else $error("opened without trigger");
endmodule

bind lww_ctrl lww_chk i_lww_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .frame_win_start(frame_win_start),
    .line_win_open(line_win_open), .frame_done(frame_done),
    .trig_in(trig_in), .in_valid(in_valid), .in_pkt(in_pkt),
    .out_valid(out_valid), .out_pkt(out_pkt)
);

// ### sim/tb_lww_ctrl.sv
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); \
        end \
    end
module tb_lww_ctrl
    import lww_pkg::*;
;
    logic ref_clk, rst_n, reg_wr, reg_rd, in_valid, out_valid;
    logic line_win_open, frame_done;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, last_out;
    logic [3:0] ev;
    lww_trig_t trig;
    lww_pkt_t in_pkt, out_pkt;
    int failures, samples_checked, n_out, n_done;

    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    lww_ctrl i_lww_ctrl (.ref_clk(ref_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acq_start(ev[0]),
        .vol_win_start(ev[1]), .frame_win_start(ev[2]), .vol_done(ev[3]),
        .line_win_open(line_win_open), .frame_done(frame_done),
        .trig_in(trig), .in_valid(in_valid), .in_pkt(in_pkt),
        .out_valid(out_valid), .out_pkt(out_pkt));
    lww_src i_src (.ref_clk(ref_clk), .in_valid(in_valid), .in_pkt(in_pkt));

    // Count words and frame ends leaving the block
    always @(posedge ref_clk) begin
        if (out_valid === 1'b1) begin
            n_out++;
            last_out = out_pkt.data[31:0];
        end
        if (frame_done === 1'b1) n_done++;
    end

    // --------------------------------------------------------------
    // Bus and event helpers
    // --------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        if (reg_wr !== 1'b0) @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        // Read data stand only in this cycle; look mid-cycle
        @(negedge ref_clk);
        `CHK(nm, e, reg_rdata)
        @(posedge ref_clk);
    endtask
    task automatic pulse(input int k);
        if (ev !== 4'h0) @(posedge ref_clk);
        ev[k] <= 1'b1;
        @(posedge ref_clk);
        ev <= 4'h0;
    endtask
    task automatic look(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // --------------------------------------------------------------
    // Tests
    // --------------------------------------------------------------
    task automatic t_regs();
        for (int i = 0; i < 7; i++) rchk("reset", 8'(4 * i), 32'h0);
        wr(8'h00, 32'h8114_4132);
        rchk("ctrl", 8'h00, 32'h0114_4132);
        wr(8'h00, 32'hffff_ffff);
        rchk("ctrl bad", 8'h00, 32'h0);
        wr(8'h04, 32'h1234_5678);
        rchk("ldim", 8'h04, 32'h1234_5678);
        wr(8'h08, 32'h8765_4321);
        rchk("wdim", 8'h08, 32'h8765_4321);
        wr(8'h14, 32'hffff_ffff);
        rchk("clr pt", 8'h14, 32'h3000_0000);
        rchk("unmapped", 8'h40, 32'h0);
        wr(8'h14, 32'h0);
        $display("test regs done");
    endtask

    task automatic t_count();
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h0001_0002);
        wr(8'h08, 32'h0001_0002);
        pulse(0);
        n_out = 0;
        n_done = 0;
        pulse(2);
        look(2);
        `CHK("open", 1'b1, line_win_open)
        @(posedge ref_clk);
        i_src.send(0, 3, 4);
        look(4);
        `CHK("words", 4, n_out)
        `CHK("last", 32'h0002_0002, last_out)
        `CHK("done", 1, n_done)
        `CHK("closed", 1'b0, line_win_open)
        @(posedge ref_clk);
        rchk("frames", 8'h10, 32'h1);
        rchk("lines", 8'h14, 32'h2);
        rchk("wcount", 8'h18, 32'h4);
        $display("test count done");
    endtask

    task automatic t_sync();
        wr(8'h00, 32'h0100_0000);
        wr(8'h04, 32'h0000_0002);
        wr(8'h08, 32'h0000_0003);
        n_out = 0;
        pulse(2);
        look(2);
        @(posedge ref_clk);
        i_src.send(2, 2, 3);
        look(4);
        `CHK("synced", 6, n_out)
        `CHK("last", 32'h0001_0002, last_out)
        @(posedge ref_clk);
        $display("test sync done");
    endtask

    task automatic t_trig();
        logic lvl;
        wr(8'h04, 32'h0000_0001);
        wr(8'h08, 32'h0000_0002);
        for (int k = 0; k <= 4; k++) begin
            lvl = (k == 1 || k == 3);
            wr(8'h00, {8'h00, 4'h1, 4'(k), 4'(k), 12'h000});
            trig <= lww_trig_t'(5'(lvl) << k);
            pulse(2);
            look(3);
            `CHK("held", 1'b0, line_win_open)
            @(posedge ref_clk);
            trig <= lww_trig_t'(5'(!lvl) << k);
            look(2);
            `CHK("opened", 1'b1, line_win_open)
            @(posedge ref_clk);
            n_out = 0;
            i_src.send(1, 1, 1);
            look(3);
            `CHK("nosync", 2, n_out)
            @(posedge ref_clk);
        end
        trig <= '0;
        $display("test trig done");
    endtask

    task automatic t_close();
        wr(8'h00, 32'h0000_0110);
        wr(8'h04, 32'h0000_ffff);
        wr(8'h08, 32'h0000_0002);
        n_out = 0;
        n_done = 0;
        pulse(2);
        look(2);
        @(posedge ref_clk);
        i_src.send(0, 1, 2);
        look(3);
        `CHK("still open", 1'b1, line_win_open)
        @(posedge ref_clk);
        trig <= lww_trig_t'(5'b00010);
        @(posedge ref_clk);
        i_src.send(0, 1, 2);
        look(3);
        `CHK("closed", 1'b0, line_win_open)
        `CHK("words", 4, n_out)
        `CHK("done", 1, n_done)
        @(posedge ref_clk);
        trig <= '0;
        $display("test close done");
    endtask

    task automatic t_cnt();
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h0000_0001);
        wr(8'h08, 32'h0000_0001);
        for (int p = 0; p < 4; p++) begin
            wr(8'h0c, {2'b00, 2'(p), 28'h0});
            pulse(3);
            pulse(3);
            rchk("vol", 8'h0c, {2'b00, 2'(p), 28'h2});
            pulse(p == 0 ? 1 : 0);
            rchk("kept", 8'h0c, {2'b00, 2'(p), 28'h2});
            pulse(p < 3 ? p : 2);
            if (p >= 2) begin
                repeat (2) @(posedge ref_clk);
                i_src.send(0, 1, 1);
            end
            repeat (3) @(posedge ref_clk);
            rchk("cleared", 8'h0c, {2'b00, 2'(p), 28'h0});
        end
        wr(8'h0c, 32'h0);
        pulse(3);
        wr(8'h0c, 32'h0);
        rchk("zeroed", 8'h0c, 32'h0);
        pulse(3);
        wr(8'h0c, 32'h0000_0005);
        rchk("not zero", 8'h0c, 32'h1);
        $display("test counters done");
    endtask

    // Main sequence
    initial begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        ev = 4'h0;
        trig = '0;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        t_regs();
        t_count();
        t_sync();
        t_trig();
        t_close();
        t_cnt();
        stop_test();
    end

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        stop_test();
    end
endmodule
